// file: include/rsb_pkg.sv
// Package of constants and types for the reading store buffer
package rsb_pkg;
    localparam int unsigned DATA_W        = 24;
    localparam int unsigned CHAN_W        = 12;
    localparam int unsigned IDX_W         = 17;
    localparam logic [16:0] MAX_POINTS    = 17'd110000;
    localparam logic [16:0] MIN_POINTS    = 17'd2;
    localparam logic [16:0] DEF_POINTS    = 17'd100;
    localparam logic [16:0] MIN_NOTIFY    = 17'd2;
    localparam logic [16:0] SDEV_BUSY_MIN = 17'd1000;
    localparam logic [11:0] NO_CHANNEL    = 12'h000;
    localparam logic [15:0] ERR_NONE      = 16'h0000;
    // Two's complement of -221 and -222
    localparam logic [15:0] ERR_SETTINGS  = 16'hFF23;
    localparam logic [15:0] ERR_RANGE     = 16'hFF22;
    localparam int unsigned FIFO_DEPTH    = 16;
    // Element select bit positions
    localparam int unsigned EL_READING    = 0;
    localparam int unsigned EL_CHANNEL    = 1;
    localparam int unsigned EL_UNITS      = 2;
    localparam int unsigned EL_INDEX      = 3;
    localparam int unsigned EL_TIME       = 4;
    localparam int unsigned EL_LIMITS     = 5;
    localparam logic [5:0]  DEF_ELEMENTS  = 6'h1D;

    typedef enum logic [1:0] {RSB_FEED_SENSE, RSB_FEED_CALC, RSB_FEED_NONE} rsb_feed_e;
    typedef enum logic [1:0] {RSB_CTL_OFF, RSB_CTL_ONCE, RSB_CTL_CONT} rsb_ctl_e;
    typedef enum logic [2:0] {RSB_ST_NONE, RSB_ST_MIN, RSB_ST_MAX, RSB_ST_MEAN,
                              RSB_ST_SDEV, RSB_ST_PEAK_TO_PEAK_STATISTIC} rsb_stat_e;

    typedef struct packed {
        logic [23:0] value;
        logic [11:0] channel;
        logic [3:0]  units;
        logic [31:0] time_tag;
        logic [3:0]  limits;
    } rsb_reading_s;
endpackage : rsb_pkg

// file: include/rsb_stream_if.sv
// Stream interface between the buffer core and its output FIFO
`timescale 1ns/1ps
interface rsb_stream_if #(parameter int unsigned W = 8);
    logic [W-1:0] data;
    logic         valid;
    logic         ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : rsb_stream_if

// file: rtl/rsb_fifo.sv
// Parameterised synchronous FIFO for readout words
`timescale 1ns/1ps
module rsb_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    rsb_stream_if.snk       in_s,
    output logic [WIDTH-1:0] out_data_o,
    output logic            out_valid_o,
    input  wire logic       out_ready_i
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      fill;
    logic             push;
    logic             pop;

    assign in_s.ready = (fill != (AW+1)'(DEPTH));
    assign push       = in_s.valid && in_s.ready;
    assign pop        = (fill != '0) && (!out_valid_o || out_ready_i);

    always_ff @(posedge sys_clk_i)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_s.data;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill   <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
            fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Registered read data
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            out_valid_o <= 1'b0;
            out_data_o  <= '0;
        end
        else if (pop)
        begin
            out_valid_o <= 1'b1;
            out_data_o  <= mem[rd_ptr];
        end
        else if (out_ready_i)
        begin
            out_valid_o <= 1'b0;
        end
    end
endmodule : rsb_fifo

// file: rtl/rsb_top.sv
// Reading store buffer: storage, readout formatting and statistics
`timescale 1ns/1ps
// How it works
// - Clear command empties buffer; contents persist
// - Auto-clear empties buffer when storage starts
// - Without auto-clear, append until full or stopped
// - Disabling auto-clear forces size to maximum
// - Size 2..max accepted; else error -222
// - Size write refused with -221 without auto-clear
// - Timestamp format change empties buffer
// - Source picks raw or math; none blocks
// - Fill-once stops after size readings stored
// - Continuous mode wraps pointer to zero
// - Off mode stores nothing
// - Full readout returns only unread, then all if buffer full
// - Selective readout from start index, count
// - Next-location equals last written index plus one
// - Count reaching threshold sets notify event bit
// - Threshold above size minus one refused, -222
// - Output words carry only selected elements
// - Non-switching readings report channel zero
// - Limits nibble: HL2, LL2, HL1, LL1, fail=1
// - Binary formats drop timestamps
// - Statistic computed only on compute command
// - Long std-dev computation raises busy
module rsb_top (
    input  wire logic                    sys_clk_i,
    input  wire logic                    rst_i,
    // Measurement path
    input  wire logic                    meas_valid_i,
    input  wire logic [23:0]             raw_value_i,
    input  wire logic [23:0]             math_value_i,
    input  wire logic                    from_switch_i,
    input  wire logic [11:0]             channel_i,
    input  wire logic [3:0]              units_i,
    input  wire logic [31:0]             time_tag_i,
    input  wire logic [3:0]              limits_i,
    // Host commands, one-cycle strobes
    input  wire logic                    clear_cmd_i,
    input  wire logic                    auto_clear_wr_i,
    input  wire logic                    auto_clear_i,
    input  wire logic                    points_wr_i,
    input  wire logic [16:0]             points_i,
    input  wire logic                    notify_wr_i,
    input  wire logic [16:0]             notify_i,
    input  wire logic                    timestamp_format_select_i,
    input  wire logic [1:0]              feed_i,
    input  wire logic                    control_wr_i,
    input  wire logic [1:0]              control_i,
    input  wire logic [5:0]              elements_i,
    input  wire logic                    ascii_format_i,
    input  wire logic                    read_all_cmd_i,
    input  wire logic                    read_sel_cmd_i,
    input  wire logic [16:0]             sel_start_i,
    input  wire logic [16:0]             sel_count_i,
    input  wire logic [2:0]              statistic_select_i,
    input  wire logic                    statistic_compute_cmd_i,
    // Outputs, with the readout ready input
    output logic                         cmd_error_o,
    output logic [15:0]                  error_code_o,
    output logic [16:0]                  points_o,
    output logic [16:0]                  next_location_o,
    output logic [16:0]                  stored_count_o,
    output logic                         storing_o,
    output logic                         notify_event_bit_o,
    output logic                         busy_o,
    output logic [47:0]                  statistic_result_o,
    output logic [76:0]                  out_data_o,
    output logic                         out_valid_o,
    input  wire logic                    out_ready_i,
    output logic                         readout_active_o
);
    localparam int unsigned OW = 77;

    rsb_pkg::rsb_reading_s mem [110000];
    rsb_pkg::rsb_reading_s rd_word;
    logic                  auto_clear;
    logic [16:0]           notify_level;
    logic                  ts_fmt_q;
    rsb_pkg::rsb_ctl_e     ctl;
    logic [16:0]           wr_ptr;
    logic                  buf_full;
    logic                  do_clear;
    logic                  do_store;
    logic                  start_store;
    // Readout engine
    logic                  rd_busy;
    logic [16:0]           rd_addr;
    logic [16:0]           rd_left;
    logic                  rd_pend;
    logic [16:0]           all_read_pos;
    // Statistics engine
    logic                  st_run;
    logic [16:0]           st_addr;
    logic                  st_pend;
    logic signed [23:0]    st_min;
    logic signed [23:0]    st_max;
    logic signed [47:0]    st_sum;
    logic [63:0]           st_sq;
    logic [2:0]            st_kind;
    logic [76:0]           fmt_word;
    rsb_stream_if #(.W(OW)) fifo_s ();

    function automatic logic [16:0] wrap_inc(input logic [16:0] v, input logic [16:0] lim);
        wrap_inc = (v + 17'd1 >= lim) ? 17'd0 : v + 17'd1;
    endfunction : wrap_inc

    assign start_store = control_wr_i && !busy_o && (control_i != 2'(rsb_pkg::RSB_CTL_OFF));
    assign do_clear    = (clear_cmd_i && !busy_o)
                       || (start_store && auto_clear)
                       || (timestamp_format_select_i != ts_fmt_q);
    assign do_store    = meas_valid_i && storing_o && !busy_o
                       && (feed_i != 2'(rsb_pkg::RSB_FEED_NONE))
                       && !(ctl == rsb_pkg::RSB_CTL_OFF)
                       && !(ctl == rsb_pkg::RSB_CTL_ONCE && buf_full);

    // Settings and error reporting
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            auto_clear   <= 1'b1;
            points_o     <= rsb_pkg::DEF_POINTS;
            notify_level <= rsb_pkg::MIN_NOTIFY;
            cmd_error_o  <= 1'b0;
            error_code_o <= rsb_pkg::ERR_NONE;
            ts_fmt_q     <= 1'b0;
        end
        else
        begin
            cmd_error_o <= 1'b0;
            ts_fmt_q    <= timestamp_format_select_i;
            if (auto_clear_wr_i && !busy_o)
            begin
                auto_clear <= auto_clear_i;
                if (!auto_clear_i)
                    points_o <= rsb_pkg::MAX_POINTS;
            end
            else if (points_wr_i && !busy_o)
            begin
                if (!auto_clear)
                begin
                    cmd_error_o  <= 1'b1;
                    error_code_o <= rsb_pkg::ERR_SETTINGS;
                end
                else if (points_i < rsb_pkg::MIN_POINTS || points_i > rsb_pkg::MAX_POINTS)
                begin
                    cmd_error_o  <= 1'b1;
                    error_code_o <= rsb_pkg::ERR_RANGE;
                end
                else
                    points_o <= points_i;
            end
            if (notify_wr_i && !busy_o)
            begin
                if (notify_i < rsb_pkg::MIN_NOTIFY || notify_i > points_o - 17'd1)
                begin
                    cmd_error_o  <= 1'b1;
                    error_code_o <= rsb_pkg::ERR_RANGE;
                end
                else
                    notify_level <= notify_i;
            end
        end
    end

    // Storage control and pointers
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            ctl             <= rsb_pkg::RSB_CTL_OFF;
            storing_o       <= 1'b0;
            wr_ptr          <= '0;
            next_location_o <= '0;
            stored_count_o  <= '0;
            buf_full        <= 1'b0;
        end
        else
        begin
            if (control_wr_i && !busy_o)
            begin
                ctl       <= rsb_pkg::rsb_ctl_e'(control_i);
                storing_o <= start_store;
            end
            if (do_clear)
            begin
                wr_ptr          <= '0;
                next_location_o <= '0;
                stored_count_o  <= '0;
                buf_full        <= 1'b0;
            end
            else if (do_store)
            begin
                wr_ptr          <= wrap_inc(wr_ptr, points_o);
                next_location_o <= wrap_inc(wr_ptr, points_o);
                if (stored_count_o != points_o)
                    stored_count_o <= stored_count_o + 17'd1;
                if (wr_ptr + 17'd1 >= points_o)
                begin
                    buf_full <= 1'b1;
                    if (ctl == rsb_pkg::RSB_CTL_ONCE)
                        storing_o <= 1'b0;
                end
            end
        end
    end

    // Reading memory; no reset so contents survive a clear
    always_ff @(posedge sys_clk_i)
    begin
        if (do_store && !do_clear)
        begin
            mem[wr_ptr].value    <= (feed_i == 2'(rsb_pkg::RSB_FEED_SENSE))
                                    ? raw_value_i : math_value_i;
            mem[wr_ptr].channel  <= from_switch_i ? channel_i : rsb_pkg::NO_CHANNEL;
            mem[wr_ptr].units    <= units_i;
            mem[wr_ptr].time_tag <= time_tag_i;
            mem[wr_ptr].limits   <= limits_i;
        end
        // Keep the word the FIFO refused
        if (st_run || !rd_pend || fifo_s.ready)
            rd_word <= mem[st_run ? st_addr : rd_addr];
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
            notify_event_bit_o <= 1'b0;
        else if (do_clear)
            notify_event_bit_o <= 1'b0;
        else if (do_store && stored_count_o + 17'd1 == notify_level)
            notify_event_bit_o <= 1'b1;
    end

    // Unselected elements read as zero
    always_comb
    begin
        fmt_word = '0;
        if (elements_i[rsb_pkg::EL_READING])
            fmt_word[76:53] = rd_word.value;
        if (elements_i[rsb_pkg::EL_CHANNEL])
            fmt_word[52:41] = rd_word.channel;
        if (elements_i[rsb_pkg::EL_UNITS])
            fmt_word[40:37] = rd_word.units;
        if (elements_i[rsb_pkg::EL_INDEX])
            fmt_word[36:20] = (rd_addr == '0) ? points_o - 17'd1 : rd_addr - 17'd1;
        if (elements_i[rsb_pkg::EL_TIME] && ascii_format_i)
            fmt_word[19:4] = rd_word.time_tag[15:0];
        if (elements_i[rsb_pkg::EL_LIMITS])
            fmt_word[3:0] = rd_word.limits;
    end

    assign fifo_s.data  = fmt_word;
    assign fifo_s.valid = rd_pend;

    // Readout engine; back-pressure holds the walk
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            rd_busy      <= 1'b0;
            rd_addr      <= '0;
            rd_left      <= '0;
            rd_pend      <= 1'b0;
            all_read_pos <= '0;
            readout_active_o <= 1'b0;
        end
        else if (do_clear)
        begin
            rd_busy      <= 1'b0;
            rd_pend      <= 1'b0;
            all_read_pos <= '0;
            readout_active_o <= 1'b0;
        end
        else
        begin
            if (rd_pend && fifo_s.ready)
                rd_pend <= 1'b0;
            if (!rd_busy && !busy_o && read_all_cmd_i)
            begin
                rd_busy <= 1'b1;
                readout_active_o <= 1'b1;
                if (buf_full && all_read_pos == next_location_o)
                begin
                    rd_addr <= '0;
                    rd_left <= stored_count_o;
                end
                else
                begin
                    rd_addr <= all_read_pos;
                    rd_left <= next_location_o - all_read_pos;
                end
                all_read_pos <= next_location_o;
            end
            else if (!rd_busy && !busy_o && read_sel_cmd_i)
            begin
                rd_busy <= 1'b1;
                readout_active_o <= 1'b1;
                rd_addr <= sel_start_i;
                rd_left <= sel_count_i;
            end
            else if (rd_busy && !st_run && (!rd_pend || fifo_s.ready))
            begin
                if (rd_left == '0)
                begin
                    rd_busy <= 1'b0;
                    readout_active_o <= 1'b0;
                end
                else
                begin
                    rd_pend <= 1'b1;
                    rd_addr <= wrap_inc(rd_addr, points_o);
                    rd_left <= rd_left - 17'd1;
                end
            end
        end
    end

    rsb_fifo #(
        .WIDTH (OW),
        .DEPTH (rsb_pkg::FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_i   (sys_clk_i),
        .rst_i       (rst_i),
        .in_s        (fifo_s),
        .out_data_o  (out_data_o),
        .out_valid_o (out_valid_o),
        .out_ready_i (out_ready_i)
    );

    // Statistics walk; result only changes on compute command
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            st_run  <= 1'b0;
            st_addr <= '0;
            st_pend <= 1'b0;
            st_min  <= '0;
            st_max  <= '0;
            st_sum  <= '0;
            st_sq   <= '0;
            st_kind <= '0;
            busy_o  <= 1'b0;
            statistic_result_o <= '0;
        end
        else if (!st_run && statistic_compute_cmd_i && !rd_busy && stored_count_o != '0)
        begin
            st_run  <= 1'b1;
            st_addr <= '0;
            st_pend <= 1'b0;
            st_kind <= statistic_select_i;
            st_sum  <= '0;
            st_sq   <= '0;
            st_min  <= 24'sh7FFFFF;
            st_max  <= -24'sh7FFFFF;
            busy_o  <= (statistic_select_i == 3'(rsb_pkg::RSB_ST_SDEV))
                       && (stored_count_o > rsb_pkg::SDEV_BUSY_MIN);
        end
        else if (st_run)
        begin
            st_pend <= (st_addr != stored_count_o);
            if (st_addr != stored_count_o)
                st_addr <= st_addr + 17'd1;
            if (st_pend)
            begin
                if ($signed(rd_word.value) < st_min)
                    st_min <= $signed(rd_word.value);
                if ($signed(rd_word.value) > st_max)
                    st_max <= $signed(rd_word.value);
                st_sum <= st_sum + 48'($signed(rd_word.value));
                st_sq  <= st_sq + 64'($signed(rd_word.value) * $signed(rd_word.value));
            end
            else if (st_addr == stored_count_o)
            begin
                st_run <= 1'b0;
                busy_o <= 1'b0;
                unique case (rsb_pkg::rsb_stat_e'(st_kind))
                    rsb_pkg::RSB_ST_MIN:  statistic_result_o <= 48'(st_min);
                    rsb_pkg::RSB_ST_MAX:  statistic_result_o <= 48'(st_max);
                    rsb_pkg::RSB_ST_MEAN: statistic_result_o <= st_sum / 48'(stored_count_o);
                    // Sum of squares; the host takes the root
                    rsb_pkg::RSB_ST_SDEV: statistic_result_o <= st_sq[47:0];
                    rsb_pkg::RSB_ST_PEAK_TO_PEAK_STATISTIC: statistic_result_o <= 48'(st_max) - 48'(st_min);
                    default:              statistic_result_o <= '0;
                endcase
            end
        end
    end
endmodule : rsb_top

// file: testbench/rsb_top_properties.sv
// Port-level checker for the reading store buffer
`timescale 1ns/1ps
module rsb_top_properties (
    input wire logic        sys_clk_i, rst_i, meas_valid_i, clear_cmd_i, auto_clear_wr_i,
    input wire logic        auto_clear_i, points_wr_i, timestamp_format_select_i,
    input wire logic        control_wr_i, statistic_compute_cmd_i, ascii_format_i, out_ready_i,
    input wire logic [1:0]  feed_i,
    input wire logic [2:0]  statistic_select_i,
    input wire logic [5:0]  elements_i,
    input wire logic [16:0] points_i,
    input logic             cmd_error_o, storing_o, notify_event_bit_o, busy_o,
    input logic             out_valid_o, readout_active_o,
    input logic [15:0]      error_code_o,
    input logic [16:0]      points_o, next_location_o, stored_count_o,
    input logic [76:0]      out_data_o
);
    logic ac;
    logic q;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    // Auto-clear mirror picks the refusal code
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i) ac <= 1'b1;
        else if (auto_clear_wr_i && !busy_o) ac <= auto_clear_i;
    end
    assign q = !clear_cmd_i && !control_wr_i;
    a_size_low: assert property (points_wr_i && ac && points_i < rsb_pkg::MIN_POINTS && !busy_o
        |=> cmd_error_o && error_code_o == rsb_pkg::ERR_RANGE) else $error("size refusal");
    a_size_fixed: assert property (points_wr_i && !ac && !busy_o |=> cmd_error_o
        && error_code_o == rsb_pkg::ERR_SETTINGS && points_o == rsb_pkg::MAX_POINTS)
        else $error("fixed size refusal");
    a_size_max: assert property (auto_clear_wr_i && !auto_clear_i && !busy_o
        |=> points_o == rsb_pkg::MAX_POINTS) else $error("size not forced");
    a_clear_zero: assert property (clear_cmd_i && !busy_o |=> stored_count_o == 17'h00000
        && next_location_o == 17'h00000 && !notify_event_bit_o) else $error("clear");
    a_fmt_clear: assert property (timestamp_format_select_i != $past(timestamp_format_select_i)
        |-> ##[1:2] stored_count_o == 17'h00000) else $error("format clear");
    a_off_hold: assert property (!storing_o && q && $stable(timestamp_format_select_i)
        |=> stored_count_o <= $past(stored_count_o)) else $error("stored while off");
    a_store_incr: assert property (storing_o && meas_valid_i && feed_i != 2'h2 && q && !busy_o
        && $stable(timestamp_format_select_i) && stored_count_o < points_o
        |=> stored_count_o == $past(stored_count_o) + 17'h00001) else $error("count");
    a_feed_none: assert property (meas_valid_i && feed_i == 2'h2 && q
        |=> stored_count_o <= $past(stored_count_o)) else $error("feed none stored");
    a_busy_only: assert property (statistic_compute_cmd_i && statistic_select_i != 3'h4 && !busy_o
        |=> !busy_o) else $error("busy raised");
    a_busy_sdev: assert property (statistic_compute_cmd_i && statistic_select_i == 3'h4
        && stored_count_o > rsb_pkg::SDEV_BUSY_MIN && !busy_o && !readout_active_o
        |=> busy_o) else $error("busy missing");
    a_bin_time: assert property (out_valid_o && !ascii_format_i |-> out_data_o[19:4] == 16'h0000)
        else $error("time in binary");
    a_unsel_zero: assert property (out_valid_o && elements_i == 6'h01
        |-> out_data_o[52:0] == 53'h0) else $error("unselected field");
    a_hold_word: assert property (out_valid_o && !out_ready_i |=> out_valid_o
        && $stable(out_data_o)) else $error("word dropped");
endmodule : rsb_top_properties
bind rsb_top rsb_top_properties i_props (.*);

// file: testbench/rsb_sink.sv
// Readout consumer on the far side, prompt, slow or stalled
`timescale 1ns/1ps
module rsb_sink (
    input  wire logic        sys_clk_i,
    input  wire logic [76:0] data_i,
    input  wire logic        valid_i,
    input  wire logic        stall_i,
    input  wire logic        slow_i,
    output logic             ready_o
);
    logic [76:0] q[$];
    initial ready_o = 1'b0;
    always @(posedge sys_clk_i)
    begin
        if (valid_i && ready_o) q.push_back(data_i);
        ready_o <= !stall_i && (!slow_i || !ready_o);
    end
endmodule : rsb_sink

// file: testbench/rsb_top_bench.sv
// Self-checking bench for the reading store buffer
`timescale 1ns/1ps
module rsb_top_bench;
    logic clk = 0, rst = 1, ac = 1, fmt = 0, stall = 0, asc = 1, err, sto, nb, bsy, ov, rdy, ra;
    logic [8:0]  stb = 0;
    logic [1:0]  feed = 0, ctl = 0;
    logic [2:0]  sel = 0;
    logic [5:0]  el = 6'h3F;
    logic [15:0] ecode;
    logic [16:0] pts = 0, ntf = 0, s0 = 0, sc = 0, po, nl, cnt;
    logic [23:0] val = 0;
    logic [47:0] res;
    logic [76:0] od;
    int n_fail = 0, num_checks = 0;
    initial forever #20 clk = ~clk;
    rsb_top i_dut (.sys_clk_i(clk), .rst_i(rst), .meas_valid_i(stb[8]), .raw_value_i(val),
        .math_value_i(val + 24'h000100), .from_switch_i(1'b0), .channel_i(12'h123),
        .units_i(val[3:0]), .time_tag_i({8'h00, val}), .limits_i(4'hA), .clear_cmd_i(stb[0]),
        .auto_clear_wr_i(stb[1]), .auto_clear_i(ac), .points_wr_i(stb[2]), .points_i(pts),
        .notify_wr_i(stb[3]), .notify_i(ntf), .timestamp_format_select_i(fmt), .feed_i(feed),
        .control_wr_i(stb[4]), .control_i(ctl), .elements_i(el), .ascii_format_i(asc),
        .read_all_cmd_i(stb[5]), .read_sel_cmd_i(stb[6]), .sel_start_i(s0), .sel_count_i(sc),
        .statistic_select_i(sel), .statistic_compute_cmd_i(stb[7]), .cmd_error_o(err),
        .error_code_o(ecode), .points_o(po), .next_location_o(nl), .stored_count_o(cnt),
        .storing_o(sto), .notify_event_bit_o(nb), .busy_o(bsy), .statistic_result_o(res),
        .out_data_o(od), .out_valid_o(ov), .out_ready_i(rdy), .readout_active_o(ra));
    rsb_sink i_sink (.sys_clk_i(clk), .data_i(od), .valid_i(ov), .stall_i(stall),
        .slow_i(asc), .ready_o(rdy));
    task end_sim;
        $display("Checks %0d, errors %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_sim
    task chk(input logic [76:0] got, input logic [76:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: got %0h, expected %0h", $time, got, exp);
        end
    endtask : chk
    task chk_err(input logic [15:0] code);
        num_checks++;
        if (err !== 1'b1 || ecode !== code)
        begin
            n_fail++;
            $display("Error at %0t: no refusal, code %0h", $time, ecode);
        end
    endtask : chk_err
    task op(input int b);
        @(negedge clk) stb[b] = 1'b1;
        @(negedge clk) stb[b] = 1'b0;
    endtask : op
    task store(input int n, input int base);
        for (int i = 0; i < n; i++)
        begin
            val = 24'(base + i);
            op(8);
        end
    endtask : store
    // Stall so words queue, then drain and count
    task rd(input int b, input int n);
        int k;
        int t;
        k = i_sink.q.size();
        stall = 1'b1;
        op(b);
        repeat (30) @(negedge clk);
        stall = 1'b0;
        for (t = 0; t < 400 && i_sink.q.size() < k + n; t++) @(negedge clk);
        if (t >= 400) begin n_fail++; $display("Error at %0t: readout timeout", $time); end_sim(); end
        repeat (20) @(negedge clk);
        chk(77'(i_sink.q.size()), 77'(k + n));
    endtask : rd
    initial
    begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        chk(po, rsb_pkg::DEF_POINTS);
        for (int i = 0; i < 3; i++)
        begin
            pts = (i == 2) ? 17'd110001 : 17'(i);
            op(2);
            chk_err(rsb_pkg::ERR_RANGE);
        end
        pts = 17'd4;
        op(2);
        chk(po, 17'd4);
        ntf = 17'd4;
        op(3);
        chk_err(rsb_pkg::ERR_RANGE);
        ntf = 17'd3;
        op(3);
        ctl = 2'h1;
        op(4);
        store(2, 0);
        chk(nb, 1'b0);
        store(4, 2);
        chk(nb, 1'b1);
        chk(cnt, 17'd4);
        chk(sto, 1'b0);
        chk(nl, 17'd0);
        rd(5, 4);
        chk(i_sink.q[0], {24'h0, 12'h000, 4'h0, 17'h0, 16'h0, 4'hA});
        chk(i_sink.q[3], {24'h3, 12'h000, 4'h3, 17'h3, 16'h3, 4'hA});
        asc = 1'b0;
        rd(5, 4);
        el = 6'h01;
        s0 = 17'd1;
        sc = 17'd2;
        rd(6, 2);
        chk(i_sink.q[i_sink.q.size() - 2], {24'h1, 53'h0});
        el = 6'h3F;
        feed = 2'h1;
        ctl = 2'h2;
        op(4);
        store(6, 0);
        chk(nl, 17'd2);
        s0 = 17'd0;
        sc = 17'd1;
        rd(6, 1);
        chk(i_sink.q[i_sink.q.size() - 1][76:53], 24'h104);
        ctl = 2'h0;
        op(4);
        store(2, 0);
        chk(nl, 17'd2);
        ctl = 2'h2;
        feed = 2'h2;
        op(4);
        store(2, 0);
        chk(cnt, 17'd0);
        feed = 2'h0;
        ac = 1'b0;
        op(1);
        chk(po, rsb_pkg::MAX_POINTS);
        pts = 17'd10;
        op(2);
        chk_err(rsb_pkg::ERR_SETTINGS);
        ctl = 2'h1;
        op(4);
        store(2, 0);
        ctl = 2'h0;
        op(4);
        ctl = 2'h1;
        op(4);
        store(1, 0);
        chk(cnt, 17'd3);
        fmt = 1'b1;
        repeat (3) @(negedge clk);
        chk(cnt, 17'd0);
        store(2, 0);
        op(0);
        chk(cnt, 17'd0);
        chk(nl, 17'd0);
        ac = 1'b1;
        op(1);
        pts = 17'd8;
        op(2);
        op(4);
        store(8, 3);
        for (int i = 0; i < 5; i++)
        begin
            sel = 3'(i + 1);
            op(7);
            repeat (20) @(negedge clk);
            chk(res, 48'(i == 0 ? 3 : i == 1 ? 10 : i == 2 ? 6 : i == 3 ? 380 : 7));
        end
        sel = 3'h1;
        repeat (5) @(negedge clk);
        chk(res, 48'd7);
        pts = 17'd1100;
        op(2);
        op(4);
        store(1001, 0);
        sel = 3'h4;
        op(7);
        chk(bsy, 1'b1);
        op(0);
        for (int t = 0; bsy !== 1'b0; t++)
        begin
            if (t > 5000) begin n_fail++; $display("Error at %0t: busy stuck", $time); end_sim(); end
            @(negedge clk);
        end
        chk(cnt, 17'd1001);
        end_sim();
    end
endmodule : rsb_top_bench
